// ---- hdl/stop_clock_defs.svh ----
// Register map, field positions and reset values of the stop-clock control
`ifndef STOP_CLOCK_DEFS_SVH
`define STOP_CLOCK_DEFS_SVH
// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define REG_PMU_CFG    8'h80
`define REG_PORT22     8'h82
`define REG_PORT70     8'h83
`define REG_SOFT_CTRL  8'h84
`define REG_EVT_CTRL   8'h85
`define REG_IRQ_MASK   8'h86
// ****************************************
// Field positions
// ****************************************
`define CFG_STOP_EN    6
`define CFG_SOFT_EN    5
`define SOFT_ASSERT    0
`define SOFT_BRK_CLR   1
`define SOFT_DET_CLR   2
`define EVT_FAST       7
`define EVT_GENERIC    6
`define EVT_SLOW       5
`define EVT_BREAK      4
`define EVT_IRQ        3
`define EVT_NMI        2
`define EVT_DMA        1
`define EVT_PCI        0
// ****************************************
// Mirrored I/O ports and reset values
// ****************************************
`define IO_PORT_22     16'h0022
`define IO_PORT_70     16'h0070
`define RST_BYTE       8'h00
`define RST_MASK       16'h0000
`define RST_WORD       32'h0000_0000
`endif

// ---- hdl/stop_clock_pkg.sv ----
// Types shared by the stop-clock control block
package stop_clock_pkg;
  typedef enum logic {
    STATE_RUN     = 1'b0,
    STATE_STOPPED = 1'b1
  } stop_state_e;
  typedef logic [7:0] byte_t;
endpackage : stop_clock_pkg

// ---- hdl/stop_clock_event_control.sv ----
// Stop-clock request control with Wishbone register slave
// What this block does
// - Read-only shadow of last port 70h write
// - Read-only shadow of last port 22h write
// - Writing bit 2 clears deturbo blocking
// - Writing bit 1 clears break blocking
// - Break press blocks further presses until cleared
// - Writing bit 0 asserts stop request immediately
// - Event bit 7 lets fast timeout assert
// - Event bit 6 lets generic timeout assert
// - Event bit 5 lets slow timeout assert
// - Event bit 4: unblocked break press releases request
// - Event bit 3: masked interrupt releases request
// - Event bit 2: NMI event releases request
// - Event bit 1: DMA request releases request
// - Event bit 0: PCI master request releases
// - Sixteen-bit mask selects wake interrupt lines
// - Master enable gates every stop request
// - Software assertion needs software enable bit
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "stop_clock_defs.svh"
module stop_clock_event_control (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        io_write_i,
  input  wire logic [15:0] io_port_i,
  input  wire logic [7:0]  io_data_i,
  input  wire logic        fast_timeout_i,
  input  wire logic        generic_timeout_i,
  input  wire logic        slow_timeout_i,
  input  wire logic        break_switch_i,
  input  wire logic        deturbo_switch_i,
  input  wire logic [15:0] irq_i,
  input  wire logic        nmi_i,
  input  wire logic        dma_req_i,
  input  wire logic        pci_req_i,
  output logic             stop_clock_request_n_o,
  output logic             break_blocked_o,
  output logic             deturbo_blocked_o,
  output logic             break_action_o,
  output logic             deturbo_action_o
);
  // ****************************************
  // State
  // ****************************************
  stop_clock_pkg::byte_t       pmu_cfg;
  stop_clock_pkg::byte_t       evt_ctrl;
  logic [15:0]                 irq_mask;
  stop_clock_pkg::byte_t       port22_shadow;
  stop_clock_pkg::byte_t       port70_shadow;
  stop_clock_pkg::stop_state_e state;
  logic                        brk_prev;
  logic                        det_prev;
  logic                        nmi_prev;
  logic [15:0]                 irq_prev;
  stop_clock_pkg::byte_t       next_pmu_cfg;
  stop_clock_pkg::byte_t       next_evt_ctrl;
  logic [15:0]                 next_irq_mask;
  stop_clock_pkg::byte_t       next_port22_shadow;
  stop_clock_pkg::byte_t       next_port70_shadow;
  stop_clock_pkg::stop_state_e next_state;
  logic [31:0]                 next_dat;
  logic                        next_ack;
  logic                        next_brk_blk;
  logic                        next_det_blk;
  logic                        next_brk_act;
  logic                        next_det_act;
  logic [7:0]                  idx;
  logic                        wr_lo;
  logic                        wr_hi;
  logic                        soft_wr;
  logic                        brk_press;
  logic                        det_press;
  logic                        nmi_rise;
  logic [15:0]                 irq_rise;
  logic                        timer_hit;
  logic                        soft_hit;
  logic                        assert_req;
  logic                        wake;

  // ****************************************
  // Wishbone slave
  // ****************************************
  assign idx     = wb_adr_i[9:2];
  // Writes land on the edge at which the master sees ack
  assign wr_lo   = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign wr_hi   = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[1];
  assign soft_wr = wr_lo & (idx == `REG_SOFT_CTRL);

  always_comb begin
    next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    next_dat = `RST_WORD;
    // Unmapped and write-only registers read as zero
    if (next_ack & ~wb_we_i) begin
      unique case (idx)
        `REG_PMU_CFG:  next_dat[7:0]  = pmu_cfg;
        `REG_PORT22:   next_dat[7:0]  = port22_shadow;
        `REG_PORT70:   next_dat[7:0]  = port70_shadow;
        `REG_EVT_CTRL: next_dat[7:0]  = evt_ctrl;
        `REG_IRQ_MASK: next_dat[15:0] = irq_mask;
        default:       next_dat       = `RST_WORD;
      endcase
    end
  end

  // ****************************************
  // Control registers and port shadows
  // ****************************************
  always_comb begin
    next_pmu_cfg       = pmu_cfg;
    next_evt_ctrl      = evt_ctrl;
    next_irq_mask      = irq_mask;
    next_port22_shadow = port22_shadow;
    next_port70_shadow = port70_shadow;
    if (wr_lo && idx == `REG_PMU_CFG) begin
      next_pmu_cfg = wb_dat_i[7:0];
    end
    if (wr_lo && idx == `REG_EVT_CTRL) begin
      next_evt_ctrl = wb_dat_i[7:0];
    end
    if (wr_lo && idx == `REG_IRQ_MASK) begin
      next_irq_mask[7:0] = wb_dat_i[7:0];
    end
    if (wr_hi && idx == `REG_IRQ_MASK) begin
      next_irq_mask[15:8] = wb_dat_i[15:8];
    end
    if (io_write_i && io_port_i == `IO_PORT_22) begin
      next_port22_shadow = io_data_i;
    end
    if (io_write_i && io_port_i == `IO_PORT_70) begin
      next_port70_shadow = io_data_i;
    end
  end

  // ****************************************
  // Switch blocking
  // ****************************************
  assign brk_press = break_switch_i & ~brk_prev;
  assign det_press = deturbo_switch_i & ~det_prev;

  always_comb begin
    next_brk_blk = break_blocked_o;
    next_det_blk = deturbo_blocked_o;
    if (soft_wr && wb_dat_i[`SOFT_BRK_CLR]) begin
      next_brk_blk = 1'b0;
    end
    if (soft_wr && wb_dat_i[`SOFT_DET_CLR]) begin
      next_det_blk = 1'b0;
    end
    // Press sets blocking, wins over clear
    if (brk_press) begin
      next_brk_blk = 1'b1;
    end
    // Deturbo needs re-arm after each press
    if (det_press) begin
      next_det_blk = 1'b1;
    end
    next_brk_act = brk_press & ~break_blocked_o;
    next_det_act = det_press & ~deturbo_blocked_o;
  end

  // ****************************************
  // Stop-clock request
  // ****************************************
  assign nmi_rise = nmi_i & ~nmi_prev;
  assign irq_rise = irq_i & ~irq_prev;
  assign timer_hit = (evt_ctrl[`EVT_FAST] & fast_timeout_i)
                   | (evt_ctrl[`EVT_GENERIC] & generic_timeout_i)
                   | (evt_ctrl[`EVT_SLOW] & slow_timeout_i);
  assign soft_hit = pmu_cfg[`CFG_SOFT_EN] & soft_wr & wb_dat_i[`SOFT_ASSERT];
  assign assert_req = pmu_cfg[`CFG_STOP_EN] & (timer_hit | soft_hit);
  assign wake = (evt_ctrl[`EVT_BREAK] & brk_press & ~break_blocked_o)
              | (evt_ctrl[`EVT_IRQ] & (|(irq_rise & irq_mask)))
              | (evt_ctrl[`EVT_NMI] & nmi_rise)
              | (evt_ctrl[`EVT_DMA] & dma_req_i)
              | (evt_ctrl[`EVT_PCI] & pci_req_i);

  always_comb begin
    next_state = state;
    // Held until wake; wake wins a tie so a waiting request is not stranded
    unique case (state)
      stop_clock_pkg::STATE_RUN: begin
        if (assert_req && !wake) begin
          next_state = stop_clock_pkg::STATE_STOPPED;
        end
      end
      stop_clock_pkg::STATE_STOPPED: begin
        if (wake) begin
          next_state = stop_clock_pkg::STATE_RUN;
        end
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o               <= 1'b0;
      wb_dat_o               <= `RST_WORD;
      pmu_cfg                <= `RST_BYTE;
      evt_ctrl               <= `RST_BYTE;
      irq_mask               <= `RST_MASK;
      port22_shadow          <= `RST_BYTE;
      port70_shadow          <= `RST_BYTE;
      state                  <= stop_clock_pkg::STATE_RUN;
      stop_clock_request_n_o <= 1'b1;
      break_blocked_o        <= 1'b0;
      deturbo_blocked_o      <= 1'b0;
      break_action_o         <= 1'b0;
      deturbo_action_o       <= 1'b0;
      brk_prev               <= 1'b0;
      det_prev               <= 1'b0;
      nmi_prev               <= 1'b0;
      irq_prev               <= `RST_MASK;
    end else begin
      wb_ack_o               <= next_ack;
      wb_dat_o               <= next_dat;
      pmu_cfg                <= next_pmu_cfg;
      evt_ctrl               <= next_evt_ctrl;
      irq_mask               <= next_irq_mask;
      port22_shadow          <= next_port22_shadow;
      port70_shadow          <= next_port70_shadow;
      state                  <= next_state;
      stop_clock_request_n_o <= (next_state == stop_clock_pkg::STATE_RUN);
      break_blocked_o        <= next_brk_blk;
      deturbo_blocked_o      <= next_det_blk;
      break_action_o         <= next_brk_act;
      deturbo_action_o       <= next_det_act;
      brk_prev               <= break_switch_i;
      det_prev               <= deturbo_switch_i;
      nmi_prev               <= nmi_i;
      irq_prev               <= irq_i;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_port70_shadow: assert property (
    io_write_i && io_port_i == `IO_PORT_70 |=> port70_shadow == $past(io_data_i))
    else $error("port 70h shadow missed a write");

  a_port22_shadow: assert property (
    io_write_i && io_port_i == `IO_PORT_22 |=> port22_shadow == $past(io_data_i))
    else $error("port 22h shadow missed a write");

  a_deturbo_clear: assert property (
    soft_wr && wb_dat_i[`SOFT_DET_CLR] && !det_press |=> !deturbo_blocked_o)
    else $error("deturbo blocking not cleared");

  a_break_clear: assert property (
    soft_wr && wb_dat_i[`SOFT_BRK_CLR] && !brk_press |=> !break_blocked_o)
    else $error("break blocking not cleared");

  a_break_block: assert property (
    break_blocked_o |=> !break_action_o)
    else $error("blocked break press acted");

  a_soft_assert: assert property (
    pmu_cfg[`CFG_STOP_EN] && soft_hit && !wake |=> !stop_clock_request_n_o)
    else $error("software assertion ignored");

  a_fast_timer: assert property (
    pmu_cfg[`CFG_STOP_EN] && evt_ctrl[`EVT_FAST] && fast_timeout_i && !wake
    |=> !stop_clock_request_n_o)
    else $error("fast timeout did not assert");

  a_generic_timer: assert property (
    pmu_cfg[`CFG_STOP_EN] && evt_ctrl[`EVT_GENERIC] && generic_timeout_i && !wake
    |=> !stop_clock_request_n_o)
    else $error("generic timeout did not assert");

  a_slow_timer: assert property (
    pmu_cfg[`CFG_STOP_EN] && evt_ctrl[`EVT_SLOW] && slow_timeout_i && !wake
    |=> !stop_clock_request_n_o)
    else $error("slow timeout did not assert");

  a_wake_release: assert property (
    wake |=> stop_clock_request_n_o)
    else $error("wake event did not release request");

  a_irq_mask: assert property (
    !stop_clock_request_n_o && !(|(irq_i & ~irq_prev & irq_mask)) && !evt_ctrl[`EVT_BREAK]
    && !evt_ctrl[`EVT_NMI] && !evt_ctrl[`EVT_DMA] && !evt_ctrl[`EVT_PCI]
    |=> !stop_clock_request_n_o)
    else $error("unselected interrupt released request");

  a_master_gate: assert property (
    $fell(stop_clock_request_n_o) |-> $past(pmu_cfg[`CFG_STOP_EN]))
    else $error("request asserted while master enable off");

  a_soft_gate: assert property (
    stop_clock_request_n_o && !timer_hit && !pmu_cfg[`CFG_SOFT_EN]
    |=> stop_clock_request_n_o)
    else $error("software assertion without its enable");

  a_stop_hold: assert property (
    !stop_clock_request_n_o && !wake |=> !stop_clock_request_n_o)
    else $error("request dropped without wake");

  a_reset_zero: assert property (
    $past(rst_i) |-> pmu_cfg == `RST_BYTE && evt_ctrl == `RST_BYTE
    && irq_mask == `RST_MASK && stop_clock_request_n_o)
    else $error("control state not zero after reset");

  a_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
endmodule : stop_clock_event_control

// ---- tb/stop_clock_host_model.sv ----
// Host processor model that watches the stop-clock request
`timescale 1ns/1ns
module stop_clock_host_model (
  input  wire logic stop_clock_request_n_i,
  output logic      stopped_o
);
  // Host core halts while the active-low request is held low
  assign stopped_o = ~stop_clock_request_n_i;
endmodule : stop_clock_host_model

// ---- tb/tb_stop_clock_event_control.sv ----
// Self-checking bench for the stop-clock request control
`timescale 1ns/1ns
module tb_stop_clock_event_control;
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic        cyc     = 1'b0;
  logic        we      = 1'b0;
  logic [9:0]  adr     = 10'h000;
  logic [31:0] wdat    = 32'h0000_0000;
  logic        io_wr   = 1'b0;
  logic [15:0] io_port = 16'h0000;
  logic [7:0]  io_dat  = 8'h00;
  logic [15:0] irq     = 16'h0000;
  logic [7:0]  src     = 8'h00;
  logic [31:0] rdat;
  logic        ack;
  logic        req_n;
  logic        brk_blk;
  logic        det_blk;
  logic        brk_act;
  logic        det_act;
  logic        stopped;
  logic [7:0]  d70;
  logic [7:0]  d22;
  logic [31:0] exp_q[$];
  logic [31:0] exp_v;
  logic [9:0]  addrs[7] = '{10'h200, 10'h208, 10'h20C, 10'h210, 10'h214, 10'h218, 10'h3FC};
  int          fail_count = 0;
  int          compares   = 0;
  int          k;

  stop_clock_event_control i_stop_clock_event_control (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .io_write_i(io_wr), .io_port_i(io_port), .io_data_i(io_dat),
    .fast_timeout_i(src[5]), .generic_timeout_i(src[4]), .slow_timeout_i(src[3]),
    .break_switch_i(src[7]), .deturbo_switch_i(src[6]), .irq_i(irq), .nmi_i(src[2]),
    .dma_req_i(src[1]), .pci_req_i(src[0]), .stop_clock_request_n_o(req_n),
    .break_blocked_o(brk_blk), .deturbo_blocked_o(det_blk),
    .break_action_o(brk_act), .deturbo_action_o(det_act)
  );

  stop_clock_host_model i_stop_clock_host_model (
    .stop_clock_request_n_i(req_n),
    .stopped_o(stopped)
  );

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic wrap_up();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  task automatic st(input logic e);
    chk(32'(e), 32'(stopped));
  endtask : st

  // Holds the request until ack is sampled, then idles one cycle
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    cyc <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      wrap_up();
    end
    @(posedge clk_i);
  endtask : wb

  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic pulse(input int b);
    src[b] <= 1'b1;
    @(posedge clk_i);
    src[b] <= 1'b0;
    @(posedge clk_i);
  endtask : pulse

  task automatic io_cycle(input logic [15:0] p, input logic [7:0] d);
    io_wr <= 1'b1;
    io_port <= p;
    io_dat <= d;
    @(posedge clk_i);
    io_wr <= 1'b0;
    @(posedge clk_i);
  endtask : io_cycle

  // Read data is judged only at the ack edge, oldest note first
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      exp_v = exp_q.pop_front();
      chk(exp_v, rdat);
    end
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    wrap_up();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hb21c904f));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    st(1'b0);
    foreach (addrs[i]) rd(addrs[i], 32'h0000_0000);
    d70 = 8'($urandom);
    d22 = 8'($urandom);
    io_cycle(16'h0070, d70);
    io_cycle(16'h0022, d22);
    io_cycle(16'h0071, ~d70);
    wb(1'b1, 10'h20C, 32'h0000_00ff);
    rd(10'h20C, 32'(d70));
    rd(10'h208, 32'(d22));
    wb(1'b1, 10'h214, 32'h0000_00e0);
    pulse(5);
    pulse(4);
    pulse(3);
    wb(1'b1, 10'h210, 32'h0000_0001);
    st(1'b0);
    wb(1'b1, 10'h200, 32'h0000_0040);
    wb(1'b1, 10'h210, 32'h0000_0001);
    st(1'b0);
    rd(10'h214, 32'h0000_00e0);
    wb(1'b1, 10'h200, 32'h0000_0060);
    wb(1'b1, 10'h210, 32'h0000_0000);
    st(1'b0);
    wb(1'b1, 10'h210, 32'h0000_0001);
    st(1'b1);
    repeat (5) @(posedge clk_i);
    st(1'b1);
    wb(1'b1, 10'h214, 32'h0000_0001);
    pulse(0);
    st(1'b0);
    for (k = 0; k < 3; k++) begin
      wb(1'b1, 10'h214, 32'h0000_0002);
      pulse(5 - k);
      st(1'b0);
      wb(1'b1, 10'h214, 32'((8'h80 >> k) | 8'h02));
      pulse(5 - k);
      st(1'b1);
      pulse(1);
      st(1'b0);
    end
    k = $urandom_range(15);
    wb(1'b1, 10'h218, 32'(16'h0001 << k));
    rd(10'h218, 32'(16'h0001 << k));
    wb(1'b1, 10'h214, 32'h0000_0088);
    pulse(5);
    irq <= ~(16'h0001 << k);
    repeat (2) @(posedge clk_i);
    st(1'b1);
    irq <= 16'hffff;
    repeat (2) @(posedge clk_i);
    st(1'b0);
    irq <= 16'h0000;
    wb(1'b1, 10'h214, 32'h0000_0080);
    pulse(5);
    pulse(2);
    st(1'b1);
    wb(1'b1, 10'h214, 32'h0000_0084);
    pulse(2);
    st(1'b0);
    wb(1'b1, 10'h214, 32'h0000_0090);
    pulse(5);
    pulse(7);
    chk(32'h0000_0001, 32'(brk_act));
    chk(32'h0000_0001, 32'(brk_blk));
    st(1'b0);
    pulse(5);
    pulse(7);
    chk(32'h0000_0000, 32'(brk_act));
    st(1'b1);
    wb(1'b1, 10'h210, 32'h0000_0000);
    chk(32'h0000_0001, 32'(brk_blk));
    wb(1'b1, 10'h210, 32'h0000_0002);
    chk(32'h0000_0000, 32'(brk_blk));
    pulse(7);
    st(1'b0);
    pulse(6);
    chk(32'h0000_0001, 32'(det_act));
    pulse(6);
    chk(32'h0000_0000, 32'(det_act));
    chk(32'h0000_0001, 32'(det_blk));
    wb(1'b1, 10'h210, 32'h0000_0004);
    chk(32'h0000_0000, 32'(det_blk));
    wrap_up();
  end
endmodule : tb_stop_clock_event_control
